/* verilog/lpw_consts.svh */
`ifndef LPW_CONSTS_SVH
`define LPW_CONSTS_SVH
// Register byte offsets
`define LPW_OFS_CTRL        8'h00
`define LPW_OFS_QUAL        8'h04
`define LPW_OFS_STAT        8'h08
// Control register fields
`define LPW_CTRL_MODE_LSB   0
`define LPW_CTRL_DIV_LSB    2
`define LPW_CTRL_QSB_LSB    8
`define LPW_CTRL_RST        32'h0000_0000
`define LPW_QUAL_RST        32'h0000_0000
// Timing counts in system clock cycles
`define LPW_QUAL_SAMPLES    3'h6
`define LPW_IDLE_WAKE_FAST  11'h008
`define LPW_IDLE_WAKE_SLOW  11'h41A
`define LPW_STBY_WAKE_FAST  11'h00C
`define LPW_STBY_WAKE_SLOW  11'h465
`define LPW_XCLK_HIGH_DLY   7'h20
`define LPW_HOLD_DIV0       7'h10
`define LPW_HOLD_DIV2       7'h20
`define LPW_HOLD_DIV3       7'h40
`define LPW_HALT_HOLD       7'h20
`define LPW_UNQ_STBY_WIDTH  6'h0C
`define LPW_NMI_MIN_WIDTH   6'h02
`define LPW_RST_MIN_WIDTH   6'h08
`endif

/* verilog/lpw_pkg.sv */
package lpw_pkg;
  // Low-power mode selection field encoding
  typedef enum logic [1:0] {
    LPW_MODE_IDLE    = 2'h0,
    LPW_MODE_STANDBY = 2'h1,
    LPW_MODE_HALT    = 2'h2,
    LPW_MODE_RSVD    = 2'h3
  } lpw_mode_e;
  // Controller states
  typedef enum logic [2:0] {
    LPW_RUN, LPW_HOLD, LPW_IDLE, LPW_STBY, LPW_HALT, LPW_RELOCK, LPW_RESUME
  } lpw_state_e;
endpackage

/* verilog/lpw_ctrl.sv */
//////////////////////////////////////////////////////////////////////////////
// Function
// - Qualification time is six sampling windows
// - Idle resume in 8 or 1050 cycles
// - Latency ends at instruction after idle
// - Idle exits on irq, watchdog, NMI, reset
// - Standby qualifier: 6-bit, count plus two
// - Standby resume in 12 or 1125 cycles
// - Clock output high 32..45 after entry
// - Idle instruction enters standby when selected
// - Standby hold 16/32/64 cycles by divider
// - Long external access fails at gating
// - Standby stops peripherals, keeps PLL, watchdog
// - After standby, service enabled waking irq
// - Qualifier samples every 2n, six equal
// - Halt holds clock 32 cycles then stops
// - NMI release starts 131072-cycle relock
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
`include "lpw_consts.svh"

module lpw_ctrl #(
  parameter int RELOCK_CYCLES = 131072, // Long count, shorten in sim
  parameter int QUAL_W        = 8       // Sample period field width
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // AXI4-Lite slave
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Core and system side
  input  wire logic        IDLE_EXEC,       // Idle instruction pulse
  input  wire logic        FLASH_SLEEPING,  // Flash in sleep state
  input  wire logic        EXT_MEM_BUSY,    // External memory access
  input  wire logic        IRQ_ENABLED,     // Any enabled interrupt
  input  wire logic        WATCHDOG_IRQ_N,  // Watchdog interrupt
  input  wire logic        EXT_NONMASKABLE_IRQ, // NMI pin
  input  wire logic        EXT_RESET_PIN_N, // External reset pin
  input  wire logic        WAKE_PIN,        // External wake pin
  output logic             CORE_CLK_EN,     // System clock gate
  output logic             PERIPH_CLK_EN,   // Peripheral clock gate
  output logic             PLL_EN,          // PLL running
  output logic             OSC_EN,          // Oscillator running
  output logic             WATCHDOG_EN,     // Watchdog running
  output logic             EXT_CLOCK_OUTPUT,// External clock output
  output logic             EXEC_RESUME,     // Execution restart pulse
  output logic             SERVICE_IRQ,     // Take waking interrupt
  output logic             EXT_MEM_FAIL     // Access cut by gating
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [31:0]        low_power_ctrl_reg_ff;  // Mode, divider, qualifier
  logic [QUAL_W-1:0]  qual_sample_period_ff;  // Idle qualifier period
  lpw_pkg::lpw_state_e state_ff;              // Controller state
  lpw_pkg::lpw_mode_e  mode;                  // Selected mode
  logic [1:0]         clock_divider_select;   // Hold length select
  logic [5:0]         standby_wake_qual_count;// Standby qualifier
  logic [2:0]         wk_sync_ff;             // Wake pin synchroniser
  logic [2:0]         nmi_sync_ff;            // NMI synchroniser
  logic [2:0]         rst_sync_ff;            // Reset pin synchroniser
  logic               wk_lvl, nmi_lvl, rst_lvl; // Agreed levels
  logic [QUAL_W:0]    qtick_ff;               // Sample window counter
  logic [2:0]         qsame_ff;               // Equal samples seen
  logic               qval_ff;                // Qualified wake level
  logic               qlast_ff;               // Last sample taken
  logic [5:0]         swidth_ff;              // Standby pulse width
  logic [5:0]         nwidth_ff;              // NMI pulse width
  logic [5:0]         rwidth_ff;              // Reset pulse width
  logic [17:0]        cnt_ff;                 // Hold/latency counter
  logic [17:0]        target_ff;              // Latency target
  logic [5:0]         xco_cnt_ff;             // Cycles since idle entry
  logic               from_stby_ff;           // Resume follows standby or halt
  logic               aw_ok_ff, w_ok_ff;      // Write halves captured
  logic [7:0]         awaddr_ff;              // Captured write address
  logic [31:0]        wdata_ff;               // Captured write data
  logic               idle_wake, stby_wake;   // Wake decisions

  // Words with byte strobes applied
  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign mode = lpw_pkg::lpw_mode_e'(
    low_power_ctrl_reg_ff[`LPW_CTRL_MODE_LSB +: 2]);
  assign clock_divider_select =
    low_power_ctrl_reg_ff[`LPW_CTRL_DIV_LSB +: 2];
  assign standby_wake_qual_count =
    low_power_ctrl_reg_ff[`LPW_CTRL_QSB_LSB +: 6];

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path: address and data accepted in either order
  assign S_AXI_AWREADY = !aw_ok_ff && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_ok_ff && !S_AXI_BVALID;
  assign S_AXI_BRESP   = 2'h0;

  // Capture address and data halves
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_ok_ff  <= 1'b0;
      w_ok_ff   <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
    end else if (aw_ok_ff && w_ok_ff) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff  <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_ok_ff  <= 1'b1;
        awaddr_ff <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_ok_ff  <= 1'b1;
        wdata_ff <= apply_strb(32'h0000_0000, S_AXI_WDATA, 4'hF);
      end
    end
  end

  // Strobes kept separately so the merge sees the live register
  logic [3:0] wstrb_ff;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wstrb_ff <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      wstrb_ff <= S_AXI_WSTRB;
    end
  end

  // Register update; unmapped writes are dropped but answered OKAY
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_power_ctrl_reg_ff <= `LPW_CTRL_RST;
      qual_sample_period_ff <= QUAL_W'(`LPW_QUAL_RST);
    end else if (aw_ok_ff && w_ok_ff) begin
      if (awaddr_ff == `LPW_OFS_CTRL) begin
        low_power_ctrl_reg_ff <= apply_strb(low_power_ctrl_reg_ff,
                                            wdata_ff, wstrb_ff)
                                 & 32'h0000_3F0F;
      end else if (awaddr_ff == `LPW_OFS_QUAL) begin
        qual_sample_period_ff <= QUAL_W'(apply_strb(
          32'(qual_sample_period_ff), wdata_ff, wstrb_ff));
      end
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_BVALID <= 1'b0;
    end else if (aw_ok_ff && w_ok_ff) begin
      S_AXI_BVALID <= 1'b1;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path: status word shows the controller state
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign S_AXI_RRESP   = 2'h0;

  // Read data registered on address accept
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      case (S_AXI_ARADDR)
        `LPW_OFS_CTRL: S_AXI_RDATA <= low_power_ctrl_reg_ff;
        `LPW_OFS_QUAL: S_AXI_RDATA <= 32'(qual_sample_period_ff);
        `LPW_OFS_STAT: S_AXI_RDATA <= {27'h0000000, EXT_MEM_FAIL,
                                       1'b0, state_ff};
        default:       S_AXI_RDATA <= 32'h0000_0000;
      endcase
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wk_sync_ff  <= 3'h0;
      nmi_sync_ff <= 3'h0;
      rst_sync_ff <= 3'h7;
    end else begin
      wk_sync_ff  <= {wk_sync_ff[1:0], WAKE_PIN};
      nmi_sync_ff <= {nmi_sync_ff[1:0], EXT_NONMASKABLE_IRQ};
      rst_sync_ff <= {rst_sync_ff[1:0], EXT_RESET_PIN_N};
    end
  end

  // Agreed levels hold their last value while the stages differ
  logic wk_lvl_ff, nmi_lvl_ff, rst_lvl_ff;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wk_lvl_ff  <= 1'b0;
      nmi_lvl_ff <= 1'b0;
      rst_lvl_ff <= 1'b0;
    end else begin
      if (wk_sync_ff[1] == wk_sync_ff[2]) wk_lvl_ff <= wk_sync_ff[2];
      if (nmi_sync_ff[1] == nmi_sync_ff[2]) nmi_lvl_ff <= nmi_sync_ff[2];
      if (rst_sync_ff[1] == rst_sync_ff[2]) rst_lvl_ff <= !rst_sync_ff[2];
    end
  end
  assign wk_lvl  = wk_lvl_ff;
  assign nmi_lvl = nmi_lvl_ff;
  assign rst_lvl = rst_lvl_ff;

  //////////////////////////////////////////////////////////////////////////
  // Idle-mode input qualifier: a sample every 2n cycles, six equal
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      qtick_ff <= '0;
      qsame_ff <= 3'h0;
      qval_ff  <= 1'b0;
      qlast_ff <= 1'b0;
    end else if (qual_sample_period_ff == '0) begin
      qval_ff  <= wk_lvl;
      qtick_ff <= '0;
      qsame_ff <= 3'h0;
    end else if (qtick_ff + 1'b1 >= {qual_sample_period_ff, 1'b0}) begin
      qtick_ff <= '0;
      qlast_ff <= wk_lvl;
      if (wk_lvl != qlast_ff) begin
        qsame_ff <= 3'h1;
      end else if (qsame_ff + 3'h1 >= `LPW_QUAL_SAMPLES) begin
        qval_ff  <= wk_lvl;
        qsame_ff <= `LPW_QUAL_SAMPLES;
      end else begin
        qsame_ff <= qsame_ff + 3'h1;
      end
    end else begin
      qtick_ff <= qtick_ff + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pulse width counters for standby and halt wake sources
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      swidth_ff <= 6'h00;
      nwidth_ff <= 6'h00;
      rwidth_ff <= 6'h00;
    end else begin
      swidth_ff <= !wk_lvl  ? 6'h00 : swidth_ff + 6'(!(&swidth_ff));
      nwidth_ff <= !nmi_lvl ? 6'h00 : nwidth_ff + 6'(!(&nwidth_ff));
      rwidth_ff <= !rst_lvl ? 6'h00 : rwidth_ff + 6'(!(&rwidth_ff));
    end
  end

  // Any of the idle wake sources ends idle
  assign idle_wake = qval_ff || IRQ_ENABLED || !WATCHDOG_IRQ_N
                   || nmi_lvl || rst_lvl;
  // Standby needs count plus two, or twelve when unqualified
  assign stby_wake = ((standby_wake_qual_count == 6'h00)
    ? (swidth_ff >= `LPW_UNQ_STBY_WIDTH)
    : (7'(swidth_ff) >= 7'(standby_wake_qual_count) + 7'h02))
    || nmi_lvl || rst_lvl || !WATCHDOG_IRQ_N;

  //////////////////////////////////////////////////////////////////////////
  // Mode sequencer
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff     <= lpw_pkg::LPW_RUN;
      cnt_ff       <= 18'h00000;
      target_ff    <= 18'h00000;
      from_stby_ff <= 1'b0;
    end else begin
      case (state_ff)
        lpw_pkg::LPW_RUN: begin
          cnt_ff <= 18'h00000;
          if (IDLE_EXEC) begin
            case (mode)
              lpw_pkg::LPW_MODE_STANDBY: begin
                state_ff <= lpw_pkg::LPW_HOLD;
                case (clock_divider_select)
                  2'h2:    target_ff <= 18'(`LPW_HOLD_DIV2);
                  2'h3:    target_ff <= 18'(`LPW_HOLD_DIV3);
                  default: target_ff <= 18'(`LPW_HOLD_DIV0);
                endcase
              end
              lpw_pkg::LPW_MODE_HALT: begin
                state_ff  <= lpw_pkg::LPW_HOLD;
                target_ff <= 18'(`LPW_HALT_HOLD);
              end
              default: state_ff <= lpw_pkg::LPW_IDLE;
            endcase
          end
        end
        lpw_pkg::LPW_HOLD: begin
          cnt_ff <= cnt_ff + 18'h00001;
          if (cnt_ff + 18'h00001 >= target_ff) begin
            cnt_ff   <= 18'h00000;
            state_ff <= (mode == lpw_pkg::LPW_MODE_HALT)
                      ? lpw_pkg::LPW_HALT : lpw_pkg::LPW_STBY;
          end
        end
        lpw_pkg::LPW_IDLE: begin
          if (idle_wake) begin
            state_ff     <= lpw_pkg::LPW_RESUME;
            from_stby_ff <= 1'b0;
            target_ff    <= FLASH_SLEEPING
              ? 18'(`LPW_IDLE_WAKE_SLOW) : 18'(`LPW_IDLE_WAKE_FAST);
          end
        end
        lpw_pkg::LPW_STBY: begin
          if (stby_wake) begin
            state_ff     <= lpw_pkg::LPW_RESUME;
            from_stby_ff <= 1'b1;
            target_ff    <= FLASH_SLEEPING
              ? 18'(`LPW_STBY_WAKE_SLOW) : 18'(`LPW_STBY_WAKE_FAST);
          end
        end
        lpw_pkg::LPW_HALT: begin
          // Wake needs a full-width pulse; NMI release starts relock
          if (rwidth_ff >= `LPW_RST_MIN_WIDTH) begin
            state_ff <= lpw_pkg::LPW_RELOCK;
          end else if (nwidth_ff >= `LPW_NMI_MIN_WIDTH && !nmi_lvl) begin
            state_ff <= lpw_pkg::LPW_RELOCK;
          end
        end
        lpw_pkg::LPW_RELOCK: begin
          cnt_ff <= cnt_ff + 18'h00001;
          if (cnt_ff + 18'h00001 >= 18'(RELOCK_CYCLES)) begin
            cnt_ff       <= 18'h00000;
            state_ff     <= lpw_pkg::LPW_RESUME;
            from_stby_ff <= 1'b1;
            target_ff    <= 18'h00001;
          end
        end
        lpw_pkg::LPW_RESUME: begin
          cnt_ff <= cnt_ff + 18'h00001;
          // Restart of the instruction after idle ends the latency
          if (cnt_ff + 18'h00001 >= target_ff) begin
            cnt_ff   <= 18'h00000;
            state_ff <= lpw_pkg::LPW_RUN;
          end
        end
        default: state_ff <= lpw_pkg::LPW_RUN;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Clock output delay: counts from idle entry through hold and standby,
  // so the output still waits 32 cycles when the hold is only 16
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      xco_cnt_ff <= 6'h00;
    end else if (state_ff != lpw_pkg::LPW_HOLD
                 && state_ff != lpw_pkg::LPW_STBY) begin
      xco_cnt_ff <= 6'h00;
    end else if (!xco_cnt_ff[5]) begin
      xco_cnt_ff <= xco_cnt_ff + 6'h01;
    end
  end

  // Clock gates and status outputs, all registered
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CORE_CLK_EN      <= 1'b1;
      PERIPH_CLK_EN    <= 1'b1;
      PLL_EN           <= 1'b1;
      OSC_EN           <= 1'b1;
      WATCHDOG_EN      <= 1'b1;
      EXT_CLOCK_OUTPUT <= 1'b0;
      EXEC_RESUME      <= 1'b0;
      SERVICE_IRQ      <= 1'b0;
      EXT_MEM_FAIL     <= 1'b0;
    end else begin
      CORE_CLK_EN   <= (state_ff != lpw_pkg::LPW_STBY)
                    && (state_ff != lpw_pkg::LPW_HALT)
                    && (state_ff != lpw_pkg::LPW_RELOCK);
      PERIPH_CLK_EN <= (state_ff == lpw_pkg::LPW_RUN);
      PLL_EN        <= (state_ff != lpw_pkg::LPW_HALT);
      OSC_EN        <= (state_ff != lpw_pkg::LPW_HALT) || nmi_lvl;
      WATCHDOG_EN   <= (state_ff != lpw_pkg::LPW_HALT);
      // Clock output goes high 32 cycles after idle entry, inside 32..45
      EXT_CLOCK_OUTPUT <= (state_ff == lpw_pkg::LPW_STBY
                           || state_ff == lpw_pkg::LPW_HOLD)
        && (7'(xco_cnt_ff) + 7'h01 >= `LPW_XCLK_HIGH_DLY);
      EXEC_RESUME   <= (state_ff == lpw_pkg::LPW_RESUME)
                    && (cnt_ff + 18'h00001 >= target_ff);
      SERVICE_IRQ   <= (state_ff == lpw_pkg::LPW_RESUME)
                    && (cnt_ff + 18'h00001 >= target_ff)
                    && from_stby_ff && IRQ_ENABLED;
      // Sticky until a new idle entry: access cut by clock gating
      if (IDLE_EXEC && state_ff == lpw_pkg::LPW_RUN) begin
        EXT_MEM_FAIL <= 1'b0;
      end else if (state_ff == lpw_pkg::LPW_HOLD
                   && cnt_ff + 18'h00001 >= target_ff && EXT_MEM_BUSY) begin
        EXT_MEM_FAIL <= 1'b1;
      end
    end
  end

endmodule // lpw_ctrl

/* tb/lpw_ctrl_asserts.sv */
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Port-level checks on the low-power sequencer and its register bus
module lpw_ctrl_asserts (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic        CORE_CLK_EN,
  input wire logic        PERIPH_CLK_EN,
  input wire logic        OSC_EN,
  input wire logic        WATCHDOG_EN,
  input wire logic        EXEC_RESUME,
  input wire logic        SERVICE_IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Restart is a lone pulse, and only with the core clock back
  sequence s_resume;
    EXEC_RESUME && CORE_CLK_EN ##1 !EXEC_RESUME;
  endsequence
  // A stalled read answer keeps its data
  sequence s_r_held;
    S_AXI_RVALID && $stable(S_AXI_RDATA);
  endsequence
  a_b_held: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("b dropped");
  a_r_held: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> s_r_held) else $error("r dropped");
  a_resp_okay: assert property (
    S_AXI_BVALID || S_AXI_RVALID |-> S_AXI_BRESP == 2'h0)
    else $error("bad response");
  a_aw_refuse: assert property (
    S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken early");
  a_ar_refuse: assert property (
    S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("read taken early");
  a_resume_pulse: assert property (
    EXEC_RESUME |-> s_resume) else $error("bad resume pulse");
  a_irq_follows: assert property (
    SERVICE_IRQ |-> EXEC_RESUME) else $error("irq without resume");
  a_halt_gate: assert property (
    $fell(OSC_EN) |-> !CORE_CLK_EN && !PERIPH_CLK_EN)
    else $error("oscillator stopped with clocks on");
  a_wdog_run: assert property (
    $fell(WATCHDOG_EN) |-> !OSC_EN) else $error("watchdog stopped");
endmodule // lpw_ctrl_asserts

bind lpw_ctrl lpw_ctrl_asserts u_chk (.CLK(CLK), .RST_N(RST_N),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .CORE_CLK_EN(CORE_CLK_EN),
  .PERIPH_CLK_EN(PERIPH_CLK_EN), .OSC_EN(OSC_EN),
  .WATCHDOG_EN(WATCHDOG_EN), .EXEC_RESUME(EXEC_RESUME),
  .SERVICE_IRQ(SERVICE_IRQ));

/* tb/lpw_wake_src.sv */
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Far-side wake source: one whole pulse per request
module lpw_wake_src (
  input  wire logic       clk,
  input  wire logic       go,     // Start a pulse
  input  wire logic [1:0] kind,   // 0 wake, 1 nmi, 2 reset, 3 watchdog
  input  wire logic [7:0] width,  // Length in cycles, bench keeps minima
  output logic            wake,
  output logic            nmi,
  output logic            rst_n,
  output logic            wdog_n
);
  logic [7:0] cnt_ff = 8'h00;  // Cycles left in the pulse
  logic [1:0] kind_ff = 2'h0;  // Which line pulses
  // Count down the pulse; a new request while busy restarts it
  always_ff @(posedge clk) begin
    if (go) begin
      cnt_ff  <= width;
      kind_ff <= kind;
    end else if (cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end
  assign wake   = cnt_ff != 8'h00 && kind_ff == 2'h0;
  assign nmi    = cnt_ff != 8'h00 && kind_ff == 2'h1;
  assign rst_n  = !(cnt_ff != 8'h00 && kind_ff == 2'h2);
  assign wdog_n = !(cnt_ff != 8'h00 && kind_ff == 2'h3);
endmodule // lpw_wake_src

/* tb/tb.sv */
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module tb;
  typedef struct {int lim; logic irq;} lpw_note_s; // Expected restart
  logic CLK, RST_N, IDLE_EXEC, FLASH_SLEEPING, EXT_MEM_BUSY, IRQ_ENABLED;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, q, rs;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, kind;
  logic [3:0] S_AXI_WSTRB;
  logic S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID;
  logic S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_ARREADY, S_AXI_RVALID, WATCHDOG_IRQ_N, EXT_NONMASKABLE_IRQ;
  logic EXT_RESET_PIN_N, WAKE_PIN, CORE_CLK_EN, PERIPH_CLK_EN, PLL_EN;
  logic OSC_EN, WATCHDOG_EN, EXT_CLOCK_OUTPUT, EXEC_RESUME, SERVICE_IRQ;
  logic EXT_MEM_FAIL, go;
  logic [7:0] width;
  int cyc = 0, wake_t, bad_count, comparisons, hold, xco, w, lim, c, qp;
  logic [31:0] rd_q[$];     // Expected read data, oldest first
  lpw_note_s lat_q[$], nt;  // Expected restarts, oldest first
  lpw_ctrl #(.RELOCK_CYCLES(16)) dut (.*);
  lpw_wake_src src (.clk(CLK), .go(go), .kind(kind), .width(width),
    .wake(WAKE_PIN), .nmi(EXT_NONMASKABLE_IRQ), .rst_n(EXT_RESET_PIN_N),
    .wdog_n(WATCHDOG_IRQ_N));
  initial begin
    CLK = 1'h0;
    forever #50 CLK = !CLK;
  end
  always @(posedge CLK) cyc <= cyc + 1;
  //////////////////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task cmp_eq(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task cmp_rng(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("MISMATCH at %0t: %0d not in %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task fail_to;
    bad_count++;
    $display("MISMATCH at %0t: wait ran out", $time);
    conclude();
  endtask
  // Write: address and data offered together, each dropped when taken
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    repeat (100) begin
      @(posedge CLK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
      if (S_AXI_BVALID === 1'h1) return;
    end
    fail_to();
  endtask
  task axi_rd(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= 1'h1;
    repeat (100) begin
      @(posedge CLK);
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
      if (S_AXI_RVALID === 1'h1) return;
    end
    fail_to();
  endtask
  // Idle instruction; counts cycles to clock gating and clock output high
  task enter(input logic [31:0] ctrl);
    axi_wr(8'h00, ctrl);
    IDLE_EXEC <= 1'h1;
    @(posedge CLK);
    IDLE_EXEC <= 1'h0;
    hold = 0;
    xco = 0;
    for (int n = 1; n < 80; n++) begin
      @(posedge CLK);
      if (EXT_CLOCK_OUTPUT === 1'h1 && xco == 0) xco = n;
      if (CORE_CLK_EN !== 1'h1 && hold == 0) hold = n;
    end
  endtask
  // Ask the far side for a pulse and wait for the noted restart
  task wake(input logic [1:0] k, input int wd, input int lm, input logic ir);
    lat_q.push_back('{lm, ir});
    wake_t = cyc;
    kind <= k;
    width <= wd[7:0];
    IRQ_ENABLED <= ir;
    go <= 1'h1;
    @(posedge CLK);
    go <= 1'h0;
    repeat (2000) begin
      @(posedge CLK);
      if (lat_q.size() == 0) begin
        IRQ_ENABLED <= 1'h0;
        repeat (20) @(posedge CLK);
        return;
      end
    end
    fail_to();
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Watcher: pairs every answer with the oldest note
  initial forever begin
    @(posedge CLK);
    if (S_AXI_RVALID === 1'h1 && S_AXI_RREADY)
      cmp_eq(S_AXI_RDATA, rd_q.pop_front());
    if (EXEC_RESUME === 1'h1) begin
      nt = lat_q.pop_front();
      cmp_rng(cyc - wake_t, 1, nt.lim);
      cmp_eq(SERVICE_IRQ, nt.irq);
    end
  end
  initial begin
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, kind, width} = '0;
    S_AXI_WSTRB = 4'hF;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID} = 4'h0;
    {S_AXI_RREADY, IDLE_EXEC, FLASH_SLEEPING, EXT_MEM_BUSY} = 4'h0;
    {IRQ_ENABLED, go, bad_count, comparisons} = '0;
    rs = 32'hC3F0AC1E;
    RST_N = 1'h0;
    repeat (16) @(posedge CLK);
    RST_N <= 1'h1;
    @(posedge CLK);
    axi_rd(8'h00, 32'h0);
    axi_rd(8'h04, 32'h0);
    q = rnd();
    axi_wr(8'h04, q);
    axi_rd(8'h04, {24'h0, q[7:0]});
    axi_wr(8'h0C, q);
    axi_rd(8'h0C, 32'h0);
    axi_wr(8'h00, q);
    axi_rd(8'h00, q & 32'h0000_3F0F);
    axi_rd(8'h08, 32'h0);
    // Idle: wake pin, nmi with flash asleep, qualified pin, watchdog
    for (int i = 0; i < 4; i++) begin
      qp = (i == 2) ? int'(rnd() % 3) + 1 : 0;
      FLASH_SLEEPING <= (i == 1);
      axi_wr(8'h04, qp);
      enter(32'h0);
      w = (i == 2) ? 12 * qp + 2 : 2 + int'(rnd() % 2);
      lim = ((i == 1) ? 1050 : 8) + 14 * qp + 8;
      wake((i == 3) ? 2'h3 : 2'(i % 2), w, lim, 1'h0);
    end
    axi_wr(8'h04, 32'h0);
    // Standby for each divider select
    for (int d = 0; d < 4; d++) begin
      FLASH_SLEEPING <= (d == 3);
      EXT_MEM_BUSY <= (d == 2);
      c = (d == 1) ? int'(rnd() % 8) + 1 : 0;
      enter(32'h1 | (d << 2) | (c << 8));
      EXT_MEM_BUSY <= 1'h0;
      lim = (d == 3) ? 64 : (d == 2) ? 32 : 16;
      cmp_rng(hold, lim, lim + 3);
      cmp_rng(xco, 32, 45);
      cmp_eq(EXT_MEM_FAIL, d == 2);
      cmp_eq({PERIPH_CLK_EN, PLL_EN, WATCHDOG_EN}, 3'h3);
      w = c ? c + 2 : 12;
      lim = ((d == 3) ? 1125 : 12) + w + 8;
      wake(2'h0, w, lim, d[0]);
    end
    // Halt, woken by a short nmi pulse, then by a reset pulse
    FLASH_SLEEPING <= 1'h0;
    enter(32'h2);
    cmp_rng(hold, 32, 35);
    cmp_eq(OSC_EN, 1'h0);
    w = 2 + int'(rnd() % 4);
    wake(2'h1, w, w + 76, 1'h1);
    enter(32'h2);
    wake(2'h2, 8, 84, 1'h1);
    conclude();
  end
endmodule // tb
